// ---- rtl/tfa_consts.svh ----
`ifndef TFA_CONSTS_SVH
`define TFA_CONSTS_SVH
// Functional notes
// [RULE_01] Accept 8 kHz master pulse, 122/244 ns.
// [RULE_02] Software sets width select matching pulse.
// [RULE_03] Detect pulse convention automatically.
// [RULE_04] Rising clock edge finds boundary when selected.
// [RULE_05] Local pulses follow detected convention.
// [RULE_06] Local clock polarity at boundary selectable.
// [RULE_07] Internal timing at multiplied 131.072 MHz.
// [RULE_08] Local pulses aligned to master pulse.
// [RULE_09] Switched data leaves three frames later.
// [RULE_10] Reset gives zero input channel delay.
// [RULE_11] Per-stream channel delay moves channel zero.
// [RULE_12] Channel plus bit delay, quarter-bit placement.
// [RULE_13] Bit delay up to 7.75 bits, quarter steps.
// [RULE_14] One bit delay register per stream.
// [RULE_15] Per-stream output advancement, earlier.
// [RULE_16] Local output advance 0/2/4/6 core cycles.
// [RULE_17] Backplane output advance 0/2/4/6 core cycles.
// [RULE_18] Each stream at its own of four rates.
// [RULE_19] Channel delay spans channels of stream rate.

`define TFA_CORE_KHZ      131072
`define TFA_FRAME_HZ      8000
`define TFA_MUL_RATIO     16
`define TFA_FP_NARROW_NS  122
`define TFA_FP_HI_NS      61
`define TFA_STREAMS       16
`define TFA_CH_DELAY_RST  8'h00
`define TFA_BIT_DELAY_RST 5'h00
`define TFA_ADV_RST       2'h0
`define TFA_RATE_RST      2'h3
`define TFA_CTRL_WIDE     2
`define TFA_CTRL_EDGE     1
`define TFA_CTRL_POL      0
`endif

// ---- rtl/tfa_pkg.sv ----
package tfa_pkg;
    typedef enum logic [2:0] {
        FS_IDLE = 3'h1,
        FS_WIDE = 3'h2,
        FS_HOLD = 3'h4
    } tfa_sync_state_t;
    typedef enum logic [1:0] {
        RATE_2M  = 2'h0,
        RATE_4M  = 2'h1,
        RATE_8M  = 2'h2,
        RATE_16M = 2'h3
    } tfa_rate_t;
    typedef logic [13:0] tfa_pos_t;
endpackage

// ---- rtl/tfa_stream_timer.sv ----
`timescale 1ns/10ps
module tfa_stream_timer
    import tfa_pkg::*;
#(
    parameter int FRAME_CYCLES = 16384,
    parameter bit MID_SAMPLE   = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire tfa_pos_t   frame_cnt,
    input  wire logic [1:0] rate,
    input  wire tfa_pos_t   delay,
    output logic            ch0_start,
    output logic            bit_strobe
);
    localparam tfa_pos_t FRAME_POS = tfa_pos_t'(FRAME_CYCLES);

    wire logic [14:0] diff     = {1'b0, frame_cnt} - {1'b0, delay};
    wire tfa_pos_t    pos      = diff[14] ? diff[13:0] + FRAME_POS
                                          : diff[13:0];
    wire logic [5:0]  bit_mask = 6'h3F >> rate;
    wire logic [5:0]  phase    = MID_SAMPLE ? (bit_mask >> 1) + 6'h01
                                            : 6'h00;
    wire logic        hit_bit  = (pos[5:0] & bit_mask) == phase;

    // Bit length shrinks with rate, so strobes follow each stream's rate.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ch0_start  <= 1'b0;
            bit_strobe <= 1'b0;
        end else begin
            ch0_start  <= pos == 14'h0000; // [RULE_18]
            bit_strobe <= hit_bit; // [RULE_18]
        end
    end
endmodule // tfa_stream_timer

// ---- rtl/tfa_frame_align.sv ----
`timescale 1ns/10ps
`include "tfa_consts.svh"
module tfa_frame_align
    import tfa_pkg::*;
#(
    parameter int FRAME_CYCLES = `TFA_CORE_KHZ * 1000 / `TFA_FRAME_HZ
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              core_clk,
    input  wire logic              master_clock_in,
    input  wire logic              master_frame_pulse_in,
    input  wire logic              frame_pulse_width_sel,
    input  wire logic              input_clock_edge_sel,
    input  wire logic              output_clock_polarity_sel,
    input  wire logic [15:0][1:0]  bp_in_rate,
    input  wire logic [15:0][1:0]  loc_in_rate,
    input  wire logic [15:0][1:0]  bp_out_rate,
    input  wire logic [15:0][1:0]  loc_out_rate,
    input  wire logic [15:0][7:0]  bp_input_channel_delay,
    input  wire logic [15:0][7:0]  loc_input_channel_delay,
    input  wire logic [15:0][4:0]  bp_input_bit_delay,
    input  wire logic [15:0][4:0]  loc_input_bit_delay,
    input  wire logic [15:0][1:0]  bp_output_advance,
    input  wire logic [15:0][1:0]  loc_output_advance,
    input  wire logic [15:0]       bp_serial_in,
    input  wire logic [15:0]       loc_serial_in,
    output logic                   local_frame_pulse_lo_out,
    output logic                   local_frame_pulse_hi_out,
    output logic                   local_clock_lo_out,
    output logic                   local_clock_hi_out,
    output logic [15:0]            bp_in_ch0,
    output logic [15:0]            loc_in_ch0,
    output logic [15:0]            bp_in_valid,
    output logic [15:0]            loc_in_valid,
    output logic [15:0]            bp_in_data,
    output logic [15:0]            loc_in_data,
    output logic [15:0]            bp_out_ch0,
    output logic [15:0]            loc_out_ch0,
    output logic [15:0]            bp_out_strobe,
    output logic [15:0]            loc_out_strobe,
    output logic [1:0]             write_bank,
    output logic [1:0]             read_bank,
    output logic                   style_gci,
    output logic                   clock_locked,
    output logic                   frame_locked
);
    localparam int CFG_W = 3 + 2 * 128 + 2 * 80 + 6 * 32;
    localparam int FP_LO_CYC =
        (`TFA_FP_NARROW_NS * `TFA_CORE_KHZ + 999999) / 1000000;
    localparam int FP_HI_CYC =
        (`TFA_FP_HI_NS * `TFA_CORE_KHZ + 999999) / 1000000;
    localparam tfa_pos_t FRAME_POS = tfa_pos_t'(FRAME_CYCLES);
    localparam tfa_pos_t LAST_POS  = tfa_pos_t'(FRAME_CYCLES - 1);
    localparam tfa_pos_t HALF_POS  = tfa_pos_t'(FRAME_CYCLES / 2);
    localparam tfa_pos_t LO_W      = tfa_pos_t'(FP_LO_CYC);
    localparam tfa_pos_t HI_W      = tfa_pos_t'(FP_HI_CYC);
    localparam tfa_pos_t LO_H      = tfa_pos_t'(FP_LO_CYC / 2);
    localparam tfa_pos_t HI_H      = tfa_pos_t'(FP_HI_CYC / 2);
    localparam logic [4:0] LOCK_CNT = 5'(`TFA_MUL_RATIO - 1);

    initial begin
        if (FRAME_CYCLES < 64 || FRAME_CYCLES > 16384) begin
            $error("FRAME_CYCLES must lie in 64..16384");
        end
    end

    // Channel delay masked to the frame's channel count, plus quarter bits.
    function automatic tfa_pos_t in_delay(input logic [1:0] r,
                                          input logic [7:0] ch,
                                          input logic [4:0] bq);
        logic [1:0] s;
        logic [7:0] chm;
        tfa_pos_t   a;
        tfa_pos_t   b;
        s   = 2'h3 - r;
        chm = ch & (8'hFF >> s); // [RULE_19]
        a   = tfa_pos_t'({6'h00, chm}) << ({2'b00, s} + 4'h6); // [RULE_11]
        b   = tfa_pos_t'({9'h000, bq}) << ({2'b00, s} + 4'h1); // [RULE_13]
        return a + b; // [RULE_12]
    endfunction

    function automatic tfa_pos_t out_delay(input logic [1:0] adv);
        tfa_pos_t step;
        step = {11'h000, adv, 1'b0};
        return (adv == 2'h0) ? 14'h0000 : FRAME_POS - step; // [RULE_15]
    endfunction

    // Configuration crossing: a snapshot handshake toward the core clock.
    wire logic [CFG_W-1:0] cfg_now = {
        frame_pulse_width_sel, input_clock_edge_sel,
        output_clock_polarity_sel,
        bp_input_channel_delay, loc_input_channel_delay,
        bp_input_bit_delay, loc_input_bit_delay,
        bp_in_rate, loc_in_rate, bp_out_rate, loc_out_rate,
        bp_output_advance, loc_output_advance};
    logic [CFG_W-1:0] cfg_hold;
    logic             cfg_req;
    logic             ack_s1;
    logic             ack_s2;
    wire logic        cfg_idle = ack_s2 == cfg_req;

    // Reset values are all zero so every stream starts with no delay.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg_hold <= '0; // [RULE_10]
            cfg_req  <= 1'b0;
        end else if (cfg_idle && cfg_now != cfg_hold) begin
            cfg_hold <= cfg_now; // [RULE_14]
            cfg_req  <= ~cfg_req;
        end
    end

    logic       rst_s1;
    logic       core_rst_n;
    always_ff @(posedge core_clk) begin
        rst_s1     <= reset_n;
        core_rst_n <= rst_s1;
    end

    logic             req_s1;
    logic             req_s2;
    logic             req_ack;
    logic [CFG_W-1:0] cfg_core;
    always_ff @(posedge core_clk) begin
        if (!core_rst_n) begin
            req_s1   <= 1'b0;
            req_s2   <= 1'b0;
            req_ack  <= 1'b0;
            cfg_core <= '0;
        end else begin
            req_s1  <= cfg_req;
            req_s2  <= req_s1;
            req_ack <= req_s2;
            if (req_s2 != req_ack) begin
                cfg_core <= cfg_hold;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= req_ack;
            ack_s2 <= ack_s1;
        end
    end

    wire logic            c_wide;
    wire logic            c_edge;
    wire logic            c_pol;
    wire logic [15:0][7:0] c_bp_ch;
    wire logic [15:0][7:0] c_loc_ch;
    wire logic [15:0][4:0] c_bp_bq;
    wire logic [15:0][4:0] c_loc_bq;
    wire logic [15:0][1:0] c_bp_ir;
    wire logic [15:0][1:0] c_loc_ir;
    wire logic [15:0][1:0] c_bp_or;
    wire logic [15:0][1:0] c_loc_or;
    wire logic [15:0][1:0] c_bp_adv;
    wire logic [15:0][1:0] c_loc_adv;
    assign {c_wide, c_edge, c_pol, c_bp_ch, c_loc_ch, c_bp_bq, c_loc_bq,
            c_bp_ir, c_loc_ir, c_bp_or, c_loc_or,
            c_bp_adv, c_loc_adv} = cfg_core;

    // Master pins are synchronised to the multiplied core clock.
    logic        mck_s1;
    logic        mck_s2;
    logic        mck_d;
    logic        fp_s1;
    logic        fp_s2;
    logic [15:0] bsi_s1;
    logic [15:0] bsi_s2;
    logic [15:0] lsi_s1;
    logic [15:0] lsi_s2;
    always_ff @(posedge core_clk) begin
        mck_s1 <= master_clock_in;
        mck_s2 <= mck_s1;
        mck_d  <= mck_s2;
        fp_s1  <= master_frame_pulse_in;
        fp_s2  <= fp_s1;
        bsi_s1 <= bp_serial_in;
        bsi_s2 <= bsi_s1;
        lsi_s1 <= loc_serial_in;
        lsi_s2 <= lsi_s1;
    end

    wire logic mck_rise = mck_s2 & ~mck_d;
    wire logic mck_fall = ~mck_s2 & mck_d;
    // Falling edges are used until software selects the rising edge.
    wire logic mck_edge = c_edge ? mck_rise : mck_fall; // [RULE_04]

    logic [4:0] per_cnt;
    logic       mclk_lock;
    always_ff @(posedge core_clk) begin
        if (!core_rst_n) begin
            per_cnt   <= 5'h00;
            mclk_lock <= 1'b0;
        end else if (mck_rise) begin
            per_cnt   <= 5'h00;
            mclk_lock <= per_cnt == LOCK_CNT; // [RULE_07]
        end else if (per_cnt != 5'h1F) begin
            per_cnt <= per_cnt + 5'h01;
        end
    end

    // A pulse lasts at most two clock edges, so four equal samples are idle.
    logic [3:0] fp_hist;
    logic       style_st;
    wire logic  all_hi = fp_hist == 4'hF;
    wire logic  all_lo = fp_hist == 4'h0;
    always_ff @(posedge core_clk) begin
        if (!core_rst_n) begin
            fp_hist  <= 4'hF;
            style_st <= 1'b1;
        end else begin
            if (mck_edge) begin
                fp_hist <= {fp_hist[2:0], fp_s2};
            end
            if (all_hi) begin
                style_st <= 1'b1; // [RULE_03]
            end else if (all_lo) begin
                style_st <= 1'b0; // [RULE_03]
            end
        end
    end

    wire logic fp_active = fp_s2 != style_st;

    tfa_sync_state_t state;
    tfa_sync_state_t next_state;
    logic            next_bnd;
    always_comb begin
        next_state = state;
        next_bnd   = 1'b0;
        case (state)
            FS_IDLE: begin
                if (mck_edge && fp_active) begin
                    next_state = c_wide ? FS_WIDE : FS_HOLD; // [RULE_01]
                    next_bnd   = ~c_wide;
                end
            end
            FS_WIDE: begin
                if (mck_edge) begin
                    next_state = fp_active ? FS_HOLD : FS_IDLE;
                    next_bnd   = fp_active; // [RULE_01]
                end
            end
            FS_HOLD: begin
                if (mck_edge && !fp_active) begin
                    next_state = FS_IDLE;
                end
            end
            default: begin
                next_state = FS_IDLE;
            end
        endcase
    end

    logic     bnd_pulse;
    tfa_pos_t frame_cnt;
    logic     sync_seen;
    logic [1:0] frame_idx;
    wire logic  at_last = frame_cnt >= LAST_POS;
    always_ff @(posedge core_clk) begin
        if (!core_rst_n) begin
            state     <= FS_IDLE;
            bnd_pulse <= 1'b0;
            frame_cnt <= 14'h0000;
            sync_seen <= 1'b0;
            frame_idx <= 2'h0;
        end else begin
            state     <= next_state;
            bnd_pulse <= next_bnd;
            if (bnd_pulse || at_last) begin
                frame_cnt <= 14'h0000; // [RULE_08]
                frame_idx <= frame_idx + 2'h1;
            end else begin
                frame_cnt <= frame_cnt + 14'h0001;
            end
            if (bnd_pulse) begin
                sync_seen <= 1'b1;
            end
        end
    end

    // The convention also sets timing: centred on the boundary or after it.
    wire logic lo_act = style_st ? (frame_cnt < LO_H ||
                                    frame_cnt >= FRAME_POS - LO_H)
                                 : frame_cnt < LO_W;
    wire logic hi_act = style_st ? (frame_cnt < HI_H ||
                                    frame_cnt >= FRAME_POS - HI_H)
                                 : frame_cnt < HI_W;

    always_ff @(posedge core_clk) begin
        if (!core_rst_n) begin
            local_frame_pulse_lo_out <= 1'b1;
            local_frame_pulse_hi_out <= 1'b1;
            local_clock_lo_out       <= 1'b0;
            local_clock_hi_out       <= 1'b0;
            write_bank               <= 2'h0;
            read_bank                <= 2'h1;
        end else begin
            local_frame_pulse_lo_out <= lo_act ^ style_st; // [RULE_05]
            local_frame_pulse_hi_out <= hi_act ^ style_st; // [RULE_05]
            local_clock_lo_out       <= frame_cnt[3] ^ c_pol; // [RULE_06]
            local_clock_hi_out       <= frame_cnt[2] ^ c_pol; // [RULE_06]
            // Bank written in frame n is read in frame n + 3.
            write_bank <= frame_idx; // [RULE_09]
            read_bank  <= frame_idx + 2'h1; // [RULE_09]
        end
    end

    logic [15:0] bi_stb;
    logic [15:0] li_stb;
    genvar i;
    generate
        for (i = 0; i < `TFA_STREAMS; i++) begin : g_stream
            tfa_stream_timer #(
                .FRAME_CYCLES (FRAME_CYCLES),
                .MID_SAMPLE   (1'b1)
            ) u_bp_in (
                .clk        (core_clk),
                .rst_n      (core_rst_n),
                .frame_cnt  (frame_cnt),
                .rate       (c_bp_ir[i]),
                .delay      (in_delay(c_bp_ir[i], c_bp_ch[i],
                                      c_bp_bq[i])), // [RULE_11]
                .ch0_start  (bp_in_ch0[i]),
                .bit_strobe (bi_stb[i])
            );
            tfa_stream_timer #(
                .FRAME_CYCLES (FRAME_CYCLES),
                .MID_SAMPLE   (1'b1)
            ) u_loc_in (
                .clk        (core_clk),
                .rst_n      (core_rst_n),
                .frame_cnt  (frame_cnt),
                .rate       (c_loc_ir[i]),
                .delay      (in_delay(c_loc_ir[i], c_loc_ch[i],
                                      c_loc_bq[i])), // [RULE_14]
                .ch0_start  (loc_in_ch0[i]),
                .bit_strobe (li_stb[i])
            );
            tfa_stream_timer #(
                .FRAME_CYCLES (FRAME_CYCLES),
                .MID_SAMPLE   (1'b0)
            ) u_bp_out (
                .clk        (core_clk),
                .rst_n      (core_rst_n),
                .frame_cnt  (frame_cnt),
                .rate       (c_bp_or[i]),
                .delay      (out_delay(c_bp_adv[i])), // [RULE_17]
                .ch0_start  (bp_out_ch0[i]),
                .bit_strobe (bp_out_strobe[i])
            );
            tfa_stream_timer #(
                .FRAME_CYCLES (FRAME_CYCLES),
                .MID_SAMPLE   (1'b0)
            ) u_loc_out (
                .clk        (core_clk),
                .rst_n      (core_rst_n),
                .frame_cnt  (frame_cnt),
                .rate       (c_loc_or[i]),
                .delay      (out_delay(c_loc_adv[i])), // [RULE_16]
                .ch0_start  (loc_out_ch0[i]),
                .bit_strobe (loc_out_strobe[i])
            );
        end
    endgenerate

    // Each sampled bit is reported one cycle after its mid-bit strobe.
    always_ff @(posedge core_clk) begin
        if (!core_rst_n) begin
            bp_in_valid  <= 16'h0000;
            loc_in_valid <= 16'h0000;
            bp_in_data   <= 16'h0000;
            loc_in_data  <= 16'h0000;
        end else begin
            bp_in_valid  <= bi_stb; // [RULE_13]
            loc_in_valid <= li_stb;
            bp_in_data   <= (bsi_s2 & bi_stb) | (bp_in_data & ~bi_stb);
            loc_in_data  <= (lsi_s2 & li_stb) | (loc_in_data & ~li_stb);
        end
    end

    logic gci_s1;
    logic lck_s1;
    logic frm_s1;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gci_s1       <= 1'b0;
            lck_s1       <= 1'b0;
            frm_s1       <= 1'b0;
            style_gci    <= 1'b0;
            clock_locked <= 1'b0;
            frame_locked <= 1'b0;
        end else begin
            gci_s1       <= ~style_st;
            lck_s1       <= mclk_lock;
            frm_s1       <= sync_seen;
            style_gci    <= gci_s1;
            clock_locked <= lck_s1;
            frame_locked <= frm_s1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!core_rst_n);

    a_boundary_align: assert property ( // [RULE_08]
        bnd_pulse |=> frame_cnt == 14'h0000)
        else $error("frame count not cleared at boundary");
    a_frame_wrap: assert property ( // [RULE_09]
        frame_cnt == LAST_POS && !bnd_pulse |=> frame_cnt == 0)
        else $error("frame count did not wrap");
    a_clock_pol: assert property ( // [RULE_06]
        frame_cnt == 0 && $stable(c_pol)
        |=> local_clock_lo_out == $past(c_pol)
            && local_clock_hi_out == $past(c_pol))
        else $error("local clock polarity wrong at boundary");
    a_pulse_idle: assert property ( // [RULE_05]
        frame_cnt == HALF_POS && $stable(style_st)
        |=> local_frame_pulse_lo_out == $past(style_st))
        else $error("local pulse idle level wrong");
    a_bank_gap: assert property ( // [RULE_09]
        read_bank == write_bank + 2'h1)
        else $error("read bank not three frames behind");
    a_lock_count: assert property ( // [RULE_07]
        mck_rise && per_cnt == LOCK_CNT |=> mclk_lock)
        else $error("clock lock not flagged");
    a_style_detect: assert property ( // [RULE_03]
        all_lo |=> !style_st)
        else $error("inverted pulse convention not detected");
    a_wide_pulse: assert property ( // [RULE_01]
        state == FS_WIDE && mck_edge && fp_active
        |=> bnd_pulse ##1 frame_cnt == 0)
        else $error("wide pulse boundary missed");
    a_zero_delay: assert property ( // [RULE_10]
        frame_cnt == 0 && c_bp_ch[0] == 0 && c_bp_bq[0] == 0 && !bnd_pulse
        && $stable(cfg_core) |=> bp_in_ch0[0])
        else $error("zero delay channel zero misplaced");

    c_boundary: cover property (bnd_pulse);
    c_gci_style: cover property (!style_st ##1 bnd_pulse);
    c_wide_sync: cover property (state == FS_WIDE ##[1:40] bnd_pulse);
endmodule // tfa_frame_align

// ---- test/tfa_far_end.sv ----
`timescale 1ns/10ps
module tfa_far_end #(
    parameter int FR = 1024
) (
    input  wire logic   core_clk,
    input  wire logic   frame_pulse_width_sel,
    input  wire logic   gci,
    output logic        master_clock_in,
    output logic        master_frame_pulse_in,
    output logic [15:0] bp_serial_in,
    output logic [15:0] loc_serial_in
);
    logic [13:0] pc = 14'h0000;
    logic        act;
    logic [13:0] open_at;
    // The wide pulse opens one clock period earlier, so its second rising
    // edge lands on the same boundary as the narrow one.
    assign open_at = 14'(FR - 8
                         - 16 * int'(frame_pulse_width_sel));
    assign act = (pc >= open_at) || (pc < 14'h0008);
    assign master_clock_in = ~pc[3];
    assign master_frame_pulse_in = act ~^ gci;
    assign bp_serial_in = 16'hA5C3;
    assign loc_serial_in = 16'h3C5A;
    always @(posedge core_clk) begin
        pc <= (pc == 14'(FR - 1)) ? 14'h0000 : pc + 14'h0001;
    end
endmodule // tfa_far_end

// ---- test/tfa_frame_align_tb.sv ----
`timescale 1ns/10ps
module tfa_frame_align_tb;
    localparam int FR = 1024;
    logic sys_clk, core_clk, act_lo, act_hi, pa, arm;
    logic reset_n = 1'b0;
    logic frame_pulse_width_sel = 1'b0;
    logic input_clock_edge_sel = 1'b1;
    logic output_clock_polarity_sel = 1'b0;
    logic gci = 1'b0;
    logic [15:0][1:0] bp_in_rate = '1, loc_in_rate = '1;
    logic [15:0][1:0] bp_out_rate = '1, loc_out_rate = '1;
    logic [15:0][1:0] bp_output_advance = '0, loc_output_advance = '0;
    logic [15:0][7:0] bp_input_channel_delay = '0;
    logic [15:0][7:0] loc_input_channel_delay = '0;
    logic [15:0][4:0] bp_input_bit_delay = '0, loc_input_bit_delay = '0;
    logic master_clock_in, master_frame_pulse_in;
    logic local_frame_pulse_lo_out, local_frame_pulse_hi_out;
    logic local_clock_lo_out, local_clock_hi_out;
    logic style_gci, clock_locked, frame_locked;
    logic [15:0] bp_serial_in, loc_serial_in, bp_in_ch0, loc_in_ch0;
    logic [15:0] bp_in_valid, loc_in_valid, bp_in_data, loc_in_data;
    logic [15:0] bp_out_ch0, loc_out_ch0, bp_out_strobe, loc_out_strobe;
    logic [1:0]  write_bank, read_bank, fp_clk, wb, ostb;
    int cnt, t_fp, t_bi, t_li, t_bo, t_lo, t_bv, nfp, run_lo, run_hi;
    int w_lo, w_hi, sel, ph0, err_count, num_checks, r, a;
    int chd[4] = '{1, 1, 2, 3};
    int bqd[4] = '{1, 7, 3, 5};

    tfa_frame_align #(.FRAME_CYCLES(FR)) tfa_frame_align_i (.*);
    tfa_far_end #(.FR(FR)) tfa_far_end_i (.*);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        core_clk = 1'b0;
        #7;
        forever #16 core_clk = ~core_clk;
    end

    assign act_lo = local_frame_pulse_lo_out ~^ gci;
    assign act_hi = local_frame_pulse_hi_out ~^ gci;

    // Time stamps in core cycles; the boundary of an active-low pulse lies
    // eight cycles after it opens.
    always @(posedge core_clk) begin
        cnt <= cnt + 1;
        pa <= act_lo;
        run_lo <= act_lo ? run_lo + 1 : 0;
        run_hi <= act_hi ? run_hi + 1 : 0;
        if (!act_lo && run_lo > 0) w_lo <= run_lo;
        if (!act_hi && run_hi > 0) w_hi <= run_hi;
        if (act_lo && !pa) begin
            t_fp <= gci ? cnt : cnt + 8;
            nfp <= nfp + 1;
            fp_clk <= {local_clock_lo_out, local_clock_hi_out};
        end
        if (bp_in_valid[sel] && arm) begin
            t_bv <= cnt;
            arm <= 1'b0;
        end
        if (bp_in_ch0[sel]) begin
            t_bi <= cnt;
            arm <= 1'b1;
        end
        if (loc_in_ch0[sel]) t_li <= cnt;
        if (bp_out_ch0[sel]) begin
            t_bo <= cnt;
            ostb[1] <= bp_out_strobe[sel];
        end
        if (loc_out_ch0[sel]) begin
            t_lo <= cnt;
            ostb[0] <= loc_out_strobe[sel];
        end
    end

    function automatic int md(input int v);
        return ((v % FR) + FR) % FR;
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_v(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_n(input string n, input int e, g);
        num_checks++;
        if (g != e) begin
            err_count++;
            $display("mismatch %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic wait_frames(input int n);
        int s;
        int k;
        s = nfp;
        for (k = 0; k < (n + 1) * FR && nfp < s + n; k++) begin
            @(posedge core_clk);
        end
        #1;
        if (nfp < s + n) begin
            err_count++;
            $display("mismatch frames expected %0d seen %0d", n, nfp - s);
            results();
        end
    endtask

    task automatic do_reset;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        chk_v("reset_out", 16'h0304, {6'h00, local_frame_pulse_lo_out,
            local_frame_pulse_hi_out, local_clock_lo_out, local_clock_hi_out,
            write_bank, read_bank, style_gci, frame_locked});
        @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_frames(4);
    endtask

    initial begin
        do_reset();
        chk_v("locks", 16'h0003,
            {14'h0, clock_locked, frame_locked});
        chk_v("style", 16'h0000, {15'h0, style_gci});
        chk_n("lo_width", 16, w_lo);
        chk_n("hi_width", 8, w_hi);
        chk_v("rbank", {14'h0, write_bank + 2'h1},
            {14'h0, read_bank});
        chk_v("bp_data", 16'hA5C3, bp_in_data);
        chk_v("loc_data", 16'h3C5A, loc_in_data);
        chk_n("bp_ch0", 0, md(t_bi - t_fp));
        chk_n("loc_ch0", 0, md(t_li - t_fp));
        ph0 = md(t_fp);
        repeat (200) @(posedge sys_clk);
        wb = write_bank;
        wait_frames(1);
        repeat (200) @(posedge sys_clk);
        chk_v("wbank", {14'h0, wb + 2'h1}, {14'h0, write_bank});
        @(posedge sys_clk);
        frame_pulse_width_sel <= 1'b1;
        wait_frames(3);
        chk_n("wide_phase", ph0, md(t_fp));
        @(posedge sys_clk);
        frame_pulse_width_sel <= 1'b0;
        gci <= 1'b1;
        do_reset();
        chk_v("style", 16'h0001, {15'h0, style_gci});
        chk_n("gci_phase", ph0, md(t_fp));
        chk_n("lo_width", 16, w_lo);
        chk_n("hi_width", 8, w_hi);
        for (a = 0; a < 2; a++) begin
            @(posedge sys_clk);
            output_clock_polarity_sel <= a[0];
            wait_frames(2);
            chk_v("clk_pol", {14'h0, {2{a[0]}}}, {14'h0, fp_clk});
        end
        // The falling edge finds the pulse half a master clock early.
        @(posedge sys_clk);
        input_clock_edge_sel <= 1'b0;
        wait_frames(3);
        chk_n("fall_phase", md(ph0 - 8), md(t_fp));
        @(posedge sys_clk);
        input_clock_edge_sel <= 1'b1;
        for (r = 0; r < 4; r++) begin
            @(posedge sys_clk);
            sel <= r * 5;
            bp_in_rate[r * 5] <= r[1:0];
            loc_in_rate[r * 5] <= r[1:0];
            bp_input_channel_delay[r * 5] <= chd[r][7:0];
            loc_input_channel_delay[r * 5] <= chd[r][7:0];
            bp_input_bit_delay[r * 5] <= bqd[r][4:0];
            loc_input_bit_delay[r * 5] <= bqd[r][4:0] + 5'h01;
            wait_frames(2);
            chk_n("bp_in_ofs", (chd[r] << (9 - r)) + (bqd[r] << (4 - r)),
                md(t_bi - t_fp));
            chk_n("loc_in_ofs",
                (chd[r] << (9 - r)) + ((bqd[r] + 1) << (4 - r)),
                md(t_li - t_fp));
            // Valid is registered one cycle after the mid-bit sample.
            chk_n("first_bit", (32 >> r) + 1,
                t_bv - t_bi);
        end
        for (a = 0; a < 4; a++) begin
            @(posedge sys_clk);
            sel <= 2 + a;
            bp_out_rate[2 + a] <= a[1:0];
            loc_out_rate[2 + a] <= 2'h3 - a[1:0];
            bp_output_advance[2 + a] <= a[1:0];
            loc_output_advance[2 + a] <= 2'h3 - a[1:0];
            wait_frames(2);
            chk_n("bp_adv", 2 * a, md(t_fp - t_bo));
            chk_n("loc_adv", 6 - 2 * a, md(t_fp - t_lo));
            chk_v("out_strobe", 16'h0003, {14'h0, ostb});
        end
        results();
    end
endmodule // tfa_frame_align_tb
